// File: rtl/alu_ops_pkg.sv
// Shared constants and types for the subtract, exclusive-OR, swap and sleep datapath.
package alu_ops_pkg;

  // Operation codes carried in the instruction word.
  typedef enum logic [3:0] {
    literal_minus_acc_op = 4'h0,
    file_minus_acc_op = 4'h1,
    file_minus_acc_with_borrow_op = 4'h2,
    nibble_exchange_op = 4'h3,
    literal_xor_op = 4'h4,
    file_xor_op = 4'h5,
    direction_load_op = 4'h6,
    sleep_op = 4'h7
  } op_code_t;

  // Core run state; only two codes, so both are legal Gray neighbours.
  typedef enum logic {
    core_awake = 1'b0,
    core_asleep = 1'b1
  } core_state_t;

  // Byte offsets of the register words on the bus.
  localparam logic [5:0] off_instr = 6'h00;
  localparam logic [5:0] off_acc = 6'h04;
  localparam logic [5:0] off_status = 6'h08;
  localparam logic [5:0] off_file_addr = 6'h0C;
  localparam logic [5:0] off_file_data = 6'h10;
  localparam logic [5:0] off_dir_a = 6'h14;
  localparam logic [5:0] off_dir_b = 6'h18;
  localparam logic [5:0] off_dir_c = 6'h1C;
  localparam logic [5:0] off_watchdog = 6'h20;

  // Instruction word fields.
  localparam int instr_op_lsb = 0;
  localparam int instr_op_msb = 3;
  localparam int instr_operand_lsb = 4;
  localparam int instr_operand_msb = 11;
  localparam int instr_dest_bit = 12;

  // Status word bit positions.
  localparam int st_carry = 0;
  localparam int st_nibble_borrow = 1;
  localparam int st_zero = 2;
  localparam int st_timeout = 3;
  localparam int st_power_down = 4;
  localparam int st_asleep = 5;

  // Direction-load operand values.
  localparam logic [7:0] dir_sel_a = 8'h05;
  localparam logic [7:0] dir_sel_b = 8'h06;
  localparam logic [7:0] dir_sel_c = 8'h07;

  // Reset values and sizes.
  localparam logic [7:0] dir_reset = 8'hFF;
  localparam logic [7:0] byte_zero = 8'h00;
  localparam logic [7:0] watchdog_clear = 8'h00;
  localparam logic [7:0] prescaler_clear = 8'h00;
  localparam logic [7:0] prescaler_last = 8'hFF;
  localparam int file_depth = 128;
  localparam logic [31:0] word_zero = 32'h0000_0000;

endpackage

// File: rtl/alu_if.sv
// Interface carrying operands and results between the core and its arithmetic unit.
`timescale 1ns/1ps
interface alu_if;
  import alu_ops_pkg::*;
  op_code_t op; // Operation to evaluate.
  logic [7:0] acc; // Accumulator operand.
  logic [7:0] file_val; // Addressed file register operand.
  logic [7:0] literal; // Literal operand.
  logic dest; // Destination bit: 0 accumulator, 1 file register.
  logic carry_in; // Current carry, used as an active-low borrow.
  logic [7:0] result; // Computed result byte.
  logic carry_out; // New carry.
  logic nibble_borrow_out; // New digit carry.
  logic zero_out; // New zero flag.
  logic upd_arith; // Carry and digit carry are to be written.
  logic upd_zero; // Zero flag is to be written.
  logic to_acc; // Result goes to the accumulator.
  logic to_file; // Result goes to the file register.
  modport core (output op, acc, file_val, literal, dest, carry_in,
                input result, carry_out, nibble_borrow_out, zero_out,
                upd_arith, upd_zero, to_acc, to_file);
  modport unit (input op, acc, file_val, literal, dest, carry_in,
                output result, carry_out, nibble_borrow_out, zero_out,
                upd_arith, upd_zero, to_acc, to_file);
endinterface

// File: rtl/alu_unit.sv
// Combinational arithmetic unit for subtract, exclusive-OR and nibble swap.
`timescale 1ns/1ps
module alu_unit
(
  alu_if.unit bus
);
  import alu_ops_pkg::*;

  // Subtract b from a with an active-low borrow; returns carry and byte.
  function automatic logic [8:0] sub_borrow(input logic [7:0] a, input logic [7:0] b,
                                            input logic nb);
    sub_borrow = {1'b0, a} + {1'b0, ~b} + {8'h00, nb};
  endfunction

  // Low-nibble carry for the same subtraction.
  function automatic logic nib_carry(input logic [7:0] a, input logic [7:0] b,
                                     input logic nb);
    logic [4:0] s;
    s = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, nb};
    nib_carry = s[4];
  endfunction

  // Zero detect on a result byte.
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == byte_zero);
  endfunction

  logic [8:0] diff; // Carry and difference of the selected subtraction.
  logic [7:0] minuend; // Literal or file register.
  logic nb; // Borrow-in, active low.

  // Evaluate the selected operation and its flag effects.
  always_comb
  begin
    minuend = bus.file_val;
    nb = 1'b1;
    bus.result = byte_zero;
    bus.upd_arith = 1'b0;
    bus.upd_zero = 1'b0;
    bus.to_acc = 1'b0;
    bus.to_file = 1'b0;
    unique case (bus.op)
      literal_minus_acc_op:
      begin
        minuend = bus.literal;
        bus.upd_arith = 1'b1;
        bus.upd_zero = 1'b1;
        bus.to_acc = 1'b1;
      end
      file_minus_acc_op:
      begin
        bus.upd_arith = 1'b1;
        bus.upd_zero = 1'b1;
        bus.to_acc = ~bus.dest;
        bus.to_file = bus.dest;
      end
      file_minus_acc_with_borrow_op:
      begin
        nb = bus.carry_in;
        bus.upd_arith = 1'b1;
        bus.upd_zero = 1'b1;
        bus.to_acc = ~bus.dest;
        bus.to_file = bus.dest;
      end
      nibble_exchange_op:
      begin
        bus.to_acc = ~bus.dest;
        bus.to_file = bus.dest;
      end
      literal_xor_op:
      begin
        bus.upd_zero = 1'b1;
        bus.to_acc = 1'b1;
      end
      file_xor_op:
      begin
        bus.upd_zero = 1'b1;
        bus.to_acc = ~bus.dest;
        bus.to_file = bus.dest;
      end
      default:
      begin
        // Direction load, sleep and unused codes touch no result.
        bus.to_acc = 1'b0;
      end
    endcase
    diff = sub_borrow(minuend, bus.acc, nb);
    bus.carry_out = diff[8];
    bus.nibble_borrow_out = nib_carry(minuend, bus.acc, nb);
    if (bus.op == nibble_exchange_op)
      bus.result = {bus.file_val[3:0], bus.file_val[7:4]};
    else if (bus.op == literal_xor_op)
      bus.result = bus.acc ^ bus.literal;
    else if (bus.op == file_xor_op)
      bus.result = bus.acc ^ bus.file_val;
    else
      bus.result = diff[7:0];
    bus.zero_out = is_zero(bus.result);
  end

endmodule

// File: rtl/exec_core.sv
// Execution core with Avalon-MM registers, file memory, flags, directions and sleep.
`timescale 1ns/1ps

// Behaviour
// - Literal minus accumulator into accumulator, flags updated.
// - File register minus accumulator, flags updated.
// - Borrow subtract also removes inverted carry.
// - Destination bit picks accumulator or file.
// - Swap nibbles, flags untouched.
// - Literal XOR into accumulator, zero only.
// - File XOR routed by destination, zero only.
// - Accumulator loads direction register five, six, seven.
// - Sleep sets timeout, clears power-down flag.
// - Sleep clears watchdog counter and prescaler.
// - Sleep signals oscillator stop on sleep_out and suspends execution.
module exec_core
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [5:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  input wire logic wake_in,
  input wire logic watchdog_tick_in,
  output logic sleep_out,
  output logic [7:0] port_a_direction_out,
  output logic [7:0] port_b_direction_out,
  output logic [7:0] port_c_direction_out,
  output logic [7:0] watchdog_counter_out
);
  import alu_ops_pkg::*;

  // The arithmetic unit is purely combinational, so every result below is
  // computed from the same-cycle bus write data and the current accumulator, carry and file registers.
  // Nothing is pipelined, which keeps one instruction to one bus write.
  alu_if alu_bus (); // Operands out, results back.

  // Bus handshake and the captured read word.
  logic ack_r; // High in the cycle a bus access completes.
  logic [31:0] readdata_r; // Captured read word.
  // Programmer-visible datapath state.
  logic [7:0] acc_r; // Accumulator.
  logic carry_r; // Carry, also the active-low borrow.
  logic nibble_borrow_flag_r; // Digit carry.
  logic zero_r; // Zero flag.
  logic timeout_flag_r; // Time-out status.
  logic power_down_flag_r; // Power-down status, active low in meaning.
  core_state_t state_r; // Awake or asleep.
  logic [6:0] file_addr_r; // Software pointer into the file memory.
  logic [7:0] file_mem [file_depth]; // General file registers.
  // Port direction and watchdog state.
  logic [7:0] port_a_direction_r; // Port A direction.
  logic [7:0] port_b_direction_r; // Port B direction.
  logic [7:0] port_c_direction_r; // Port C direction.
  logic [7:0] watchdog_counter_r; // Watchdog count.
  logic [7:0] prescaler_r; // Watchdog prescaler.
  // Decode results; all are combinational and valid only within the cycle.
  logic wr_fire; // Write completes this edge.
  logic exec; // An instruction executes this edge.
  op_code_t op; // Decoded operation.
  logic [7:0] operand; // Literal or address field.
  logic [6:0] op_addr; // File address from the instruction.

  // Decode the instruction word straight from the bus write data.
  // There is no instruction register: the word is only meaningful at the
  // edge where the write completes, which is also the edge that executes it.
  // Codes above the sleep code decode to nothing and leave all state alone.
  // Only seven operand bits address the file, so larger values wrap.
  always_comb
  begin
    wr_fire = write_in & ack_r;
    op = op_code_t'(writedata_in[instr_op_msb:instr_op_lsb]);
    operand = writedata_in[instr_operand_msb:instr_operand_lsb];
    op_addr = operand[6:0];
    // Sleeping suspends execution, so instruction writes are dropped.
    exec = wr_fire & (address_in == off_instr) & (state_r == core_awake);
  end

  // Feed the arithmetic unit.
  // The file operand is read asynchronously from the array, which keeps the
  // whole instruction inside one clock at the cost of a wide read multiplexer.
  // The destination bit is passed raw; the unit decides whether it matters.
  assign alu_bus.op = op;
  assign alu_bus.acc = acc_r;
  assign alu_bus.file_val = file_mem[op_addr];
  assign alu_bus.literal = operand;
  assign alu_bus.dest = writedata_in[instr_dest_bit];
  assign alu_bus.carry_in = carry_r;

  alu_unit u_alu
  (
    .bus(alu_bus.unit)
  );

  // Each access waits one cycle, which gives read data a full cycle to settle.
  // The master must keep its request up until it sees waitrequest low; a master
  // that drops early simply never completes its access.
  // Waitrequest depends on the request itself, which the bus allows.
  assign waitrequest_out = (read_in | write_in) & ~ack_r;
  assign readdata_out = readdata_r;

  // Bus handshake: ack alternates so back-to-back accesses still take two cycles.
  // The price is half the peak bus rate, which is ample for register traffic.
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      ack_r <= 1'b0;
    else
      ack_r <= (read_in | write_in) & ~ack_r;
  end

  // Read multiplexer, captured on the first cycle of a read.
  // Capturing early shows the state before the completing edge, so a read
  // placed after an instruction's write already sees that instruction's result.
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      readdata_r <= word_zero;
    else if (read_in & ~ack_r)
    begin
      readdata_r <= word_zero;
      unique case (address_in)
        off_acc: readdata_r[7:0] <= acc_r;
        // Status gathers flags from several registers into one word.
        off_status:
        begin
          readdata_r[st_carry] <= carry_r;
          readdata_r[st_nibble_borrow] <= nibble_borrow_flag_r;
          readdata_r[st_zero] <= zero_r;
          readdata_r[st_timeout] <= timeout_flag_r;
          readdata_r[st_power_down] <= power_down_flag_r;
          readdata_r[st_asleep] <= (state_r == core_asleep);
        end
        off_file_addr: readdata_r[6:0] <= file_addr_r;
        off_file_data: readdata_r[7:0] <= file_mem[file_addr_r];
        off_dir_a: readdata_r[7:0] <= port_a_direction_r;
        off_dir_b: readdata_r[7:0] <= port_b_direction_r;
        off_dir_c: readdata_r[7:0] <= port_c_direction_r;
        off_watchdog: readdata_r[7:0] <= watchdog_counter_r;
        default: readdata_r <= word_zero; // Unmapped reads return zero.
      endcase
    end
  end

  // Accumulator: software load or instruction result.
  // Both sources cannot meet in one edge, since each needs its own bus write;
  // the instruction branch is listed first only to make the order explicit.
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      acc_r <= byte_zero;
    else if (exec & alu_bus.to_acc)
      acc_r <= alu_bus.result;
    // Software load through the bus.
    else if (wr_fire & (address_in == off_acc))
      acc_r <= writedata_in[7:0];
  end

  // Arithmetic flags: instruction effects or a software status write.
  // Swap, direction load and sleep leave both update strobes low, so the
  // flags simply hold through them.
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      carry_r <= 1'b0;
      nibble_borrow_flag_r <= 1'b0;
      zero_r <= 1'b0;
    end
    // Only the flags the operation names are written.
    else if (exec)
    begin
      if (alu_bus.upd_arith)
      begin
        carry_r <= alu_bus.carry_out;
        nibble_borrow_flag_r <= alu_bus.nibble_borrow_out;
      end
      if (alu_bus.upd_zero)
        zero_r <= alu_bus.zero_out;
    end
    // Software may preset the flags, which is how a borrow chain is seeded.
    else if (wr_fire & (address_in == off_status))
    begin
      carry_r <= writedata_in[st_carry];
      nibble_borrow_flag_r <= writedata_in[st_nibble_borrow];
      zero_r <= writedata_in[st_zero];
    end
  end

  // Run state and power status; a wake request ends sleep.
  // Time-out and power-down start high and are only ever changed by sleep;
  // the watchdog overflow that would clear time-out lies outside this block.
  // A sleep write and a wake in the same edge leave the core asleep.
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_r <= core_awake;
      timeout_flag_r <= 1'b1;
      power_down_flag_r <= 1'b1;
    end
    // Sleep is listed first so that it beats a coincident wake.
    else if (exec & (op == sleep_op))
    begin
      state_r <= core_asleep;
      timeout_flag_r <= 1'b1;
      power_down_flag_r <= 1'b0;
    end
    // Wake is harmless while awake; it only leaves the asleep state.
    else if (wake_in)
      state_r <= core_awake;
  end

  // Stopped oscillator is signalled outward for the clock logic.
  // The clock itself keeps running here so that the bus and wake stay alive.
  // Gating it is left to whoever owns the oscillator.
  assign sleep_out = (state_r == core_asleep);

  // File memory pointer for software access.
  // Only seven bits are kept, matching the reach of an instruction's address.
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      file_addr_r <= byte_zero[6:0];
    else if (wr_fire & (address_in == off_file_addr))
      file_addr_r <= writedata_in[6:0];
  end

  // File memory has no reset: it powers up undefined, as general registers do.
  // An instruction and a software data write never share an edge, so the
  // single write port never has two writers.
  // Software must write a location before an instruction reads it.
  always_ff @(posedge clock_in)
  begin
    if (exec & alu_bus.to_file)
      file_mem[op_addr] <= alu_bus.result;
    // Software write through the pointer.
    else if (wr_fire & (address_in == off_file_data))
      file_mem[file_addr_r] <= writedata_in[7:0];
  end

  // Direction registers loaded from the accumulator; other operands are ignored.
  // All ones at reset keeps every pin an input until software decides.
  // The accumulator value taken is the one before the executing edge.
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      port_a_direction_r <= dir_reset;
      port_b_direction_r <= dir_reset;
      port_c_direction_r <= dir_reset;
    end
    else if (exec & (op == direction_load_op))
    begin
      // The three compares are exclusive, so at most one register loads.
      if (operand == dir_sel_a)
        port_a_direction_r <= acc_r;
      if (operand == dir_sel_b)
        port_b_direction_r <= acc_r;
      if (operand == dir_sel_c)
        port_c_direction_r <= acc_r;
    end
  end

  // Direction outputs come straight from their registers.
  assign port_a_direction_out = port_a_direction_r;
  assign port_b_direction_out = port_b_direction_r;
  assign port_c_direction_out = port_c_direction_r;

  // Watchdog: prescaler counts ticks, counter counts prescaler wraps.
  // The clear by sleep wins over a tick in the same cycle so sleep starts from zero.
  // The counter wraps silently; the time-out reset it would raise is not here.
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      prescaler_r <= prescaler_clear;
      watchdog_counter_r <= watchdog_clear;
    end
    // Sleep clears both stages together.
    else if (exec & (op == sleep_op))
    begin
      prescaler_r <= prescaler_clear;
      watchdog_counter_r <= watchdog_clear;
    end
    // A tick advances the prescaler every edge it is high.
    else if (watchdog_tick_in)
    begin
      prescaler_r <= prescaler_r + 8'h01;
      // Count one on the tick that wraps the prescaler.
      if (prescaler_r == prescaler_last)
        watchdog_counter_r <= watchdog_counter_r + 8'h01;
    end
  end

  // Direct register output, so readers outside see no glitches.
  assign watchdog_counter_out = watchdog_counter_r;

endmodule

// File: tb/exec_core_asserts.sv
// Checker for the execution core's bus handshake, sleep, watchdog and direction outputs.
`timescale 1ns/1ps
module exec_core_asserts
  import alu_ops_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [5:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic waitrequest_out,
  input wire logic wake_in,
  input wire logic watchdog_tick_in,
  input wire logic sleep_out,
  input wire logic [7:0] port_a_direction_out,
  input wire logic [7:0] port_b_direction_out,
  input wire logic [7:0] port_c_direction_out,
  input wire logic [7:0] watchdog_counter_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  // An instruction counts only at the edge where its bus write completes while awake.
  logic instr_go;
  logic sleep_go;
  logic dir_go;
  assign instr_go = write_in && !waitrequest_out && address_in == off_instr && !sleep_out;
  assign sleep_go = instr_go && writedata_in[3:0] == sleep_op;
  assign dir_go = instr_go && writedata_in[3:0] == direction_load_op;
  a_wait_one_cycle: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
    else $error("bus access not answered after one wait cycle");
  a_wait_first: assert property ($rose(read_in || write_in) |-> waitrequest_out)
    else $error("bus access answered without a wait cycle");
  a_sleep_enters: assert property (sleep_go |=> sleep_out [*2])
    else $error("sleep instruction did not stop the core");
  a_sleep_wdog_clear: assert property (sleep_go |=> watchdog_counter_out == watchdog_clear)
    else $error("sleep instruction did not clear the watchdog");
  a_sleep_holds: assert property (sleep_out && !wake_in |=> sleep_out)
    else $error("core woke without a wake request");
  a_wake_leaves: assert property (sleep_out && wake_in |=> !sleep_out)
    else $error("core stayed asleep after a wake request");
  a_dir_only_load: assert property (!dir_go |=> $stable(port_a_direction_out)
    && $stable(port_b_direction_out) && $stable(port_c_direction_out))
    else $error("direction changed without a direction load");
  a_dir_a_guarded: assert property (dir_go && writedata_in[11:4] != dir_sel_a
    |=> $stable(port_a_direction_out))
    else $error("port A direction loaded for another operand");
  a_wdog_idle: assert property (!sleep_go && !watchdog_tick_in
    |=> $stable(watchdog_counter_out))
    else $error("watchdog moved without a tick");
  c_sleep: cover property (sleep_go);
  c_wake: cover property (sleep_out && wake_in);
  c_dir: cover property (dir_go);
  c_wdog_cleared: cover property (sleep_go && watchdog_counter_out != watchdog_clear);
endmodule

bind exec_core exec_core_asserts chk (.clock_in(clock_in), .arst_n_in(arst_n_in),
  .address_in(address_in), .read_in(read_in), .write_in(write_in),
  .writedata_in(writedata_in), .waitrequest_out(waitrequest_out), .wake_in(wake_in),
  .watchdog_tick_in(watchdog_tick_in), .sleep_out(sleep_out),
  .port_a_direction_out(port_a_direction_out), .port_b_direction_out(port_b_direction_out),
  .port_c_direction_out(port_c_direction_out), .watchdog_counter_out(watchdog_counter_out));

// File: tb/subtract_xor_swap_sleep_ops_test.sv
// Self-checking bench for the execution core.
`timescale 1ns/1ps
module subtract_xor_swap_sleep_ops_test;
  import alu_ops_pkg::*;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [5:0] address_in = 6'h00;
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [31:0] writedata_in = 32'h0;
  logic wake_in = 1'b0;
  logic watchdog_tick_in = 1'b0;
  logic [31:0] readdata_out;
  logic waitrequest_out;
  logic sleep_out;
  logic [7:0] dir_a;
  logic [7:0] dir_b;
  logic [7:0] dir_c;
  logic [7:0] wdog;
  logic [31:0] rd; // Last word read over the bus.
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  exec_core dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .wake_in(wake_in),
    .watchdog_tick_in(watchdog_tick_in), .sleep_out(sleep_out),
    .port_a_direction_out(dir_a), .port_b_direction_out(dir_b),
    .port_c_direction_out(dir_c), .watchdog_counter_out(wdog));
  // Free-running 100 MHz clock.
  initial forever #5 clock_in = ~clock_in;
  // Hang guard; the whole run needs well under two thousand cycles.
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus access; an idle edge follows so the strobe never toggles twice in one step.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    address_in <= a;
    writedata_in <= d;
    write_in <= wr;
    read_in <= !wr;
    @(posedge clock_in);
    // Only the run's own cycle ceiling ends a wait that never completes.
    while (waitrequest_out !== 1'b0)
      @(posedge clock_in);
    rd = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic exec(input logic [3:0] op, input logic [7:0] opnd, input logic d);
    bus(1'b1, off_instr, {19'h0, d, opnd, op});
  endtask
  // Loads accumulator, file register 7F and the three arithmetic flags.
  task automatic put(input logic [7:0] a, input logic [7:0] f, input logic [2:0] st);
    bus(1'b1, off_acc, {24'h0, a});
    bus(1'b1, off_file_addr, 32'h7F);
    bus(1'b1, off_file_data, {24'h0, f});
    bus(1'b1, off_status, {29'h0, st});
  endtask
  // Borrow is an inverted carry, so a plain subtract adds one in place of the carry.
  task automatic sub_case(input logic [3:0] op, input logic [7:0] a, input logic [7:0] f,
                          input logic c, input logic d);
    logic cin;
    logic [7:0] res;
    logic cy;
    logic dc;
    cin = (op == file_minus_acc_with_borrow_op) ? c : 1'b1;
    // Flags from the comparisons: carry when acc plus the borrow does not exceed f.
    res = f - a - {7'h00, ~cin};
    cy = ({1'b0, a} + {8'h00, ~cin}) <= {1'b0, f};
    dc = ({1'b0, a[3:0]} + {4'h0, ~cin}) <= {1'b0, f[3:0]};
    put(a, (op == literal_minus_acc_op) ? 8'h99 : f, {2'b00, c});
    exec(op, (op == literal_minus_acc_op) ? f : 8'h7F, d);
    rdchk(off_acc, {24'h0, (d && op != literal_minus_acc_op) ? a : res});
    rdchk(off_file_data, {24'h0, (op == literal_minus_acc_op) ? 8'h99 : d ? res : f});
    rdchk(off_status, {27'h0, 2'b11, res == 8'h00, dc, cy});
  endtask
  task automatic t_reset_values();
    rdchk(off_status, 32'h18);
    rdchk(6'h3C, 32'h0);
    chk({dir_a, dir_b, dir_c, wdog}, 32'hFFFF_FF00);
  endtask
  task automatic t_literal_sub();
    sub_case(literal_minus_acc_op, 8'h05, 8'h05, 1'b0, 1'b0);
    sub_case(literal_minus_acc_op, 8'h06, 8'h05, 1'b1, 1'b0);
    sub_case(literal_minus_acc_op, 8'h10, 8'h0F, 1'b0, 1'b1);
    sub_case(literal_minus_acc_op, 8'h00, 8'hFF, 1'b0, 1'b0);
  endtask
  task automatic t_file_sub();
    sub_case(file_minus_acc_op, 8'h01, 8'h80, 1'b0, 1'b1);
    sub_case(file_minus_acc_op, 8'h90, 8'h8F, 1'b1, 1'b0);
    sub_case(file_minus_acc_op, 8'hFF, 8'hFF, 1'b0, 1'b1);
  endtask
  task automatic t_borrow_sub();
    sub_case(file_minus_acc_with_borrow_op, 8'h10, 8'h10, 1'b1, 1'b1);
    sub_case(file_minus_acc_with_borrow_op, 8'h10, 8'h10, 1'b0, 1'b1);
    sub_case(file_minus_acc_with_borrow_op, 8'h0F, 8'h20, 1'b0, 1'b0);
  endtask
  task automatic t_swap();
    put(8'h00, 8'hA5, 3'b111);
    exec(nibble_exchange_op, 8'h7F, 1'b1);
    rdchk(off_file_data, 32'h5A);
    exec(nibble_exchange_op, 8'h7F, 1'b0);
    rdchk(off_acc, 32'hA5);
    rdchk(off_status, 32'h1F);
  endtask
  task automatic t_xor();
    put(8'h3C, 8'h0F, 3'b011);
    exec(literal_xor_op, 8'h3C, 1'b1);
    rdchk(off_acc, 32'h00);
    rdchk(off_status, 32'h1F);
    exec(literal_xor_op, 8'h5A, 1'b0);
    exec(file_xor_op, 8'h7F, 1'b1);
    rdchk(off_file_data, 32'h55);
    rdchk(off_acc, 32'h5A);
    rdchk(off_status, 32'h1B);
  endtask
  task automatic t_dir();
    for (int i = 5; i < 9; i++)
    begin
      bus(1'b1, off_acc, 32'h10 + i);
      exec(direction_load_op, 8'(i), 1'b0);
    end
    chk({8'h0, dir_a, dir_b, dir_c}, 32'h0015_1617);
    rdchk(off_status, 32'h1B);
  endtask
  // Ticks stay high through the sleep write, so the clear must beat the count.
  task automatic t_sleep();
    put(8'h33, 8'h00, 3'b000);
    watchdog_tick_in <= 1'b1;
    repeat (300) @(posedge clock_in);
    exec(sleep_op, 8'h00, 1'b0);
    watchdog_tick_in <= 1'b0;
    chk({23'h0, sleep_out, wdog}, 32'h100);
    rdchk(off_status, 32'h28);
    exec(literal_xor_op, 8'hFF, 1'b0);
    rdchk(off_acc, 32'h33);
    wake_in <= 1'b1;
    @(posedge clock_in);
    wake_in <= 1'b0;
    @(posedge clock_in);
    chk({31'h0, sleep_out}, 32'h0);
    watchdog_tick_in <= 1'b1;
    repeat (254) @(posedge clock_in);
    watchdog_tick_in <= 1'b0;
    @(posedge clock_in);
    chk({24'h0, wdog}, 32'h0);
    watchdog_tick_in <= 1'b1;
    @(posedge clock_in);
    watchdog_tick_in <= 1'b0;
    @(posedge clock_in);
    chk({24'h0, wdog}, 32'h1);
  endtask
  initial
  begin
    repeat (4) @(posedge clock_in);
    arst_n_in <= 1'b1;
    @(posedge clock_in);
    t_reset_values();
    t_literal_sub();
    t_file_sub();
    t_borrow_sub();
    t_swap();
    t_xor();
    t_dir();
    t_sleep();
    tally_and_finish();
  end
endmodule
